// ==== verilog/uis_core.sv ====
/*
  uart channel support: interrupt identification, dma requests,
  sleep control, receive idle detect, break, baud generator
  assumes: fifo, shifters and flow control live outside and report
  their state on plain status inputs; registers on a plain port
*/
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "uis_params.svh"
// How it works
// - no interrupt pending reads code 000001
// - line status first; errors drained, overrun on read
// - time-out code 001100, cleared by data read
// - receive data code 000100, cleared by read
// - transmit code 000010, cleared ident read/write
// - highest pending type shown; modem cleared by read
// - xoff clears on xon; special on status read
// - flow pin rising code 100000, ident read clears
// - enable bits gate each type and output
// - status bit 7 while any fifo error
// - status bits 4:2 show head flags
// - any enable 3:0 or 5 means interrupt mode
// - fifo control bit 3 with bit 0 picks dma mode
// - mode 0 transmit empty, receive any held
// - mode 0 receive request drops when empty
// - mode 1 transmit on free space, not full
// - mode 1 receive on trigger/timeout, drops empty/error
// - sleep needs both enables and quiet channel
// - sleep stops baud; wakes on line activity
// - idle after four chars high; break drives low
// - divisor after optional divide-by-4 prescale
// - zero divisor gives no baud clock
// - reset clears enables; divisor kept
module uis_core #(
    parameter int DIV_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // fifo and shifter status from the channel datapath
    input wire logic rx_data_available,
    input wire logic rx_above_trigger,
    input wire logic rx_fifo_error,
    input wire logic [2:0] rx_head_flags,
    input wire logic rx_overrun,
    input wire logic rx_timeout,
    input wire logic tx_holding_empty,
    input wire logic tx_above_trigger,
    input wire logic tx_free_trigger,
    input wire logic tx_fifo_full,
    input wire logic tx_shift_empty,
    // flow control and modem events
    input wire logic xoff_seen,
    input wire logic xon_seen,
    input wire logic special_seen,
    input wire logic flow_pin_rise,
    input wire logic [3:0] modem_pins,
    // serial line
    input wire logic rx_line,
    input wire logic tx_serial,
    output logic tx_line,
    // outputs
    output logic irq,
    output logic tx_dma_request,
    output logic rx_dma_request,
    output logic baud_tick,
    output logic uart_clk_run
);
    import uis_pkg::*;
    localparam int IDLE_W = 16;
    localparam logic [IDLE_W-1:0] IDLE_TICKS =
        IDLE_W'(`UIS_IDLE_CHARS * `UIS_BITS_PER_CHAR * `UIS_OVERSAMPLE);
    // ==========================================================
    // control registers
    logic [7:0] ier_q, ier_d; // interrupt_enable_reg
    logic [7:0] fcr_q, fcr_d; // fifo_control_reg
    logic [7:0] lcr_q, lcr_d; // line_control_reg
    logic [7:0] mcr_q, mcr_d; // modem_control_reg
    logic [7:0] efr_q, efr_d; // enhanced_feature_reg
    logic [7:0] dll_q, dll_d; // divisor_low_byte
    logic [7:0] dlh_q, dlh_d; // divisor_high_byte
    // ==========================================================
    // interrupt source latches
    logic ovr_q, ovr_d; // overrun pending
    logic tx_q, tx_d; // transmit pending
    logic msc_q, msc_d; // modem change pending
    logic xoff_q, xoff_d; // xoff pending
    logic spc_q, spc_d; // special char pending
    logic flow_q, flow_d; // flow pin pending
    logic [3:0] delta_q, delta_d; // modem deltas
    logic [3:0] pins_q; // previous modem pins
    logic tx_src_q; // previous transmit source
    // ==========================================================
    // idle, sleep and break state
    logic [IDLE_W-1:0] idle_q, idle_d; // ticks of high line
    logic rx_prev_q; // previous line level
    uis_sleep_type slp_q, slp_d;
    logic [7:0] rdata_d;
    uis_ident_type ident;
    logic tx_src, ier_rd, lsr_rd, msr_rd, rhr_rd, iir_rd, thr_wr;
    logic rx_idle, pins_chg, wake, sleep_ok;
    logic [7:0] lsr_val;
    // ==========================================================
    // access decode
    always_comb begin
        rhr_rd = rd && addr == `UIS_OFS_RHR;
        iir_rd = rd && addr == `UIS_OFS_IIR;
        lsr_rd = rd && addr == `UIS_OFS_LSR;
        msr_rd = rd && addr == `UIS_OFS_MSR;
        ier_rd = rd && addr == `UIS_OFS_IER;
        thr_wr = wr && addr == `UIS_OFS_RHR;
    end
    // transmit source per fifo mode
    always_comb begin
        if (fcr_q[`UIS_FCR_EN]) begin
            tx_src = tx_above_trigger;
        end else begin
            tx_src = tx_holding_empty;
        end
    end
    // ==========================================================
    // line status: bit 7 while any fifo error, head flags else zero
    always_comb begin
        lsr_val = 8'h00;
        lsr_val[`UIS_LSR_FIFOERR] = rx_fifo_error;
        lsr_val[4:2] = rx_data_available ? rx_head_flags : 3'h0;
        lsr_val[1] = ovr_q;
        lsr_val[0] = rx_data_available;
        lsr_val[5] = tx_holding_empty;
        lsr_val[6] = tx_holding_empty && tx_shift_empty;
    end
    // ==========================================================
    // interrupt latches; a new event wins over a clear in one cycle
    always_comb begin
        pins_chg = modem_pins != pins_q;
        delta_d = delta_q;
        if (msr_rd) begin
            delta_d = 4'h0;
        end
        delta_d = delta_d | (modem_pins ^ pins_q);
        msc_d = (msc_q && !msr_rd) || pins_chg;
        ovr_d = (ovr_q && !lsr_rd) || rx_overrun;
        // transmit: raised on source rising, cleared by ident read or write
        tx_d = tx_q;
        if ((iir_rd && ident == `UIS_ID_TX) || thr_wr) begin
            tx_d = 1'b0;
        end
        if (tx_src && !tx_src_q) begin
            tx_d = 1'b1;
        end
        xoff_d = (xoff_q && !xon_seen) || xoff_seen;
        spc_d = (spc_q && !lsr_rd) || special_seen;
        flow_d = (flow_q && !(iir_rd && ident == `UIS_ID_FLOW)) || flow_pin_rise;
    end
    // ==========================================================
    // priority encoder: highest enabled pending type wins
    always_comb begin
        ident = `UIS_ID_NONE;
        if (ier_q[5] && flow_q) begin
            ident = `UIS_ID_FLOW;
        end
        if (ier_q[5] && (xoff_q || spc_q)) begin
            ident = `UIS_ID_XOFF;
        end
        if (ier_q[3] && msc_q) begin
            ident = `UIS_ID_MODEM;
        end
        if (ier_q[1] && tx_q) begin
            ident = `UIS_ID_TX;
        end
        if (ier_q[0] && (fcr_q[`UIS_FCR_EN] ? rx_above_trigger : rx_data_available)) begin
            ident = `UIS_ID_RXD;
        end
        if (ier_q[0] && rx_timeout) begin
            ident = `UIS_ID_TOUT;
        end
        // framing, parity, break driven by the fifo error bit
        if (ier_q[2] && (rx_fifo_error || ovr_q)) begin
            ident = `UIS_ID_LINE;
        end
    end
    // ==========================================================
    // receive idle, sleep entry and wake
    always_comb begin
        rx_idle = idle_q >= IDLE_TICKS;
        idle_d = idle_q;
        if (!rx_line) begin
            idle_d = '0;
        end else if (baud_tick && !rx_idle) begin
            idle_d = idle_q + IDLE_W'(1);
        end
        wake = (rx_line != rx_prev_q) || pins_chg || thr_wr;
        sleep_ok = efr_q[`UIS_EFR_ENH] && ier_q[`UIS_IER_SLEEP] && rx_idle
            && tx_holding_empty && tx_shift_empty && !rx_data_available
            && (ident == `UIS_ID_NONE || ident == `UIS_ID_TX
            || ident == `UIS_ID_TOUT);
        slp_d = slp_q;
        unique case (slp_q)
            UIS_AWAKE: begin
                if (sleep_ok && !wake) begin
                    slp_d = UIS_ASLEEP;
                end
            end
            UIS_ASLEEP: begin
                if (wake || !efr_q[`UIS_EFR_ENH] || !ier_q[`UIS_IER_SLEEP]) begin
                    slp_d = UIS_AWAKE;
                end
            end
        endcase
    end
    // ==========================================================
    // register writes
    always_comb begin
        ier_d = ier_q;
        fcr_d = fcr_q;
        lcr_d = lcr_q;
        mcr_d = mcr_q;
        efr_d = efr_q;
        dll_d = dll_q;
        dlh_d = dlh_q;
        if (wr) begin
            unique case (addr)
                `UIS_OFS_IER: ier_d = wdata;
                `UIS_OFS_IIR: fcr_d = wdata;
                `UIS_OFS_LCR: lcr_d = wdata;
                `UIS_OFS_MCR: mcr_d = wdata;
                `UIS_OFS_EFR: efr_d = wdata;
                `UIS_OFS_DLL: dll_d = wdata;
                `UIS_OFS_DLH: dlh_d = wdata;
                default: ;
            endcase
        end
    end
    // read data, valid the cycle after the strobe
    always_comb begin
        rdata_d = 8'h00;
        if (rd) begin
            unique case (addr)
                `UIS_OFS_IER: rdata_d = ier_q;
                `UIS_OFS_IIR: rdata_d = {2'h0, ident};
                `UIS_OFS_LCR: rdata_d = lcr_q;
                `UIS_OFS_MCR: rdata_d = mcr_q;
                `UIS_OFS_LSR: rdata_d = lsr_val;
                `UIS_OFS_MSR: rdata_d = {modem_pins, delta_q};
                `UIS_OFS_DLL: rdata_d = dll_q;
                `UIS_OFS_DLH: rdata_d = dlh_q;
                `UIS_OFS_EFR: rdata_d = efr_q;
                `UIS_OFS_STA: rdata_d = {6'h00, slp_q == UIS_ASLEEP, rx_idle};
                default: rdata_d = 8'h00;
            endcase
        end
    end
    // ==========================================================
    // control registers; divisor bytes have no reset term
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ier_q <= 8'h00;
            fcr_q <= 8'h00;
            lcr_q <= `UIS_LCR_RESET;
            mcr_q <= 8'h00;
            efr_q <= 8'h00;
            ovr_q <= 1'b0;
            tx_q <= 1'b0;
            msc_q <= 1'b0;
            xoff_q <= 1'b0;
            spc_q <= 1'b0;
            flow_q <= 1'b0;
            delta_q <= 4'h0;
            pins_q <= 4'h0;
            tx_src_q <= 1'b0;
            idle_q <= '0;
            rx_prev_q <= 1'b1;
            slp_q <= UIS_AWAKE;
            rdata <= 8'h00;
        end else begin
            ier_q <= ier_d;
            fcr_q <= fcr_d;
            lcr_q <= lcr_d;
            mcr_q <= mcr_d;
            efr_q <= efr_d;
            ovr_q <= ovr_d;
            tx_q <= tx_d;
            msc_q <= msc_d;
            xoff_q <= xoff_d;
            spc_q <= spc_d;
            flow_q <= flow_d;
            delta_q <= delta_d;
            pins_q <= modem_pins;
            tx_src_q <= tx_src;
            idle_q <= idle_d;
            rx_prev_q <= rx_line;
            slp_q <= slp_d;
            rdata <= rdata_d;
        end
    end
    // divisor latch survives reset, so it is clocked without one
    always_ff @(posedge clk) begin
        dll_q <= dll_d;
        dlh_q <= dlh_d;
    end
    // ==========================================================
    // outputs
    always_comb begin
        uart_clk_run = slp_q == UIS_AWAKE;
        irq = ident != `UIS_ID_NONE;
        tx_line = lcr_q[`UIS_LCR_BREAK] ? 1'b0 : tx_serial;
        if (fcr_q[`UIS_FCR_DMA] && fcr_q[`UIS_FCR_EN]) begin
            tx_dma_request = tx_free_trigger && !tx_fifo_full;
            rx_dma_request = (rx_above_trigger || rx_timeout) && rx_data_available
                && !rx_fifo_error;
        end else begin
            tx_dma_request = tx_holding_empty && tx_shift_empty;
            rx_dma_request = rx_data_available;
        end
    end
    // baud generator, halted while asleep
    uis_baud_gen #(.DIV_W(DIV_W)) u_baud (
        .clk(clk),
        .rst(rst),
        .run(uart_clk_run),
        .prescale_on(mcr_q[`UIS_MCR_PRE]),
        .divisor({dlh_q, dll_q}),
        .tick(baud_tick)
    );
endmodule // uis_core
`default_nettype wire

// ==== verilog/uis_params.svh ====
/*
  timing, field and reset constants for the uart support block
  assumes: included by the design files of this block (uis_core, uis_baud_gen); the package does not include it
*/
`ifndef UIS_PARAMS_SVH
`define UIS_PARAMS_SVH
// ==========================================================
// register offsets on the plain port (byte index)
`define UIS_OFS_RHR 4'h0
`define UIS_OFS_IER 4'h1
`define UIS_OFS_IIR 4'h2
`define UIS_OFS_LCR 4'h3
`define UIS_OFS_MCR 4'h4
`define UIS_OFS_LSR 4'h5
`define UIS_OFS_MSR 4'h6
`define UIS_OFS_DLL 4'h8
`define UIS_OFS_DLH 4'h9
`define UIS_OFS_EFR 4'hA
`define UIS_OFS_EVT 4'hB
`define UIS_OFS_STA 4'hC
// ==========================================================
// identification codes
`define UIS_ID_NONE 6'h01
`define UIS_ID_LINE 6'h06
`define UIS_ID_TOUT 6'h0C
`define UIS_ID_RXD 6'h04
`define UIS_ID_TX 6'h02
`define UIS_ID_MODEM 6'h00
`define UIS_ID_XOFF 6'h10
`define UIS_ID_FLOW 6'h20
// ==========================================================
// field positions
`define UIS_FCR_EN 0
`define UIS_FCR_DMA 3
`define UIS_EFR_ENH 4
`define UIS_IER_SLEEP 4
`define UIS_LCR_BREAK 6
`define UIS_MCR_PRE 7
`define UIS_LSR_FIFOERR 7
// ==========================================================
// reset values and timing
`define UIS_LCR_RESET 8'h1D
`define UIS_IDLE_CHARS 4
`define UIS_BITS_PER_CHAR 10
`define UIS_OVERSAMPLE 16
`define UIS_PRESCALE 4
`endif

// ==== verilog/uis_pkg.sv ====
/*
  types shared by the uart support block
  assumes: nothing beyond the params header
*/
package uis_pkg;
    // ==========================================================
    // types
    typedef logic [5:0] uis_ident_type;
    typedef enum logic [1:0] {UIS_AWAKE, UIS_ASLEEP} uis_sleep_type;
endpackage

// ==== verilog/uis_baud_gen.sv ====
/*
  baud generator: optional divide-by-4 prescale then 16-bit divisor
  assumes: single clock domain, divisor steady while running
*/
`timescale 1ns/1ps
`default_nettype none
`include "uis_params.svh"
module uis_baud_gen #(
    parameter int DIV_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic prescale_on,
    input wire logic [DIV_W-1:0] divisor,
    // sixteen-times tick
    output logic tick
);
    import uis_pkg::*;
    logic [1:0] pre_q, pre_d; // prescale counter
    logic [DIV_W-1:0] cnt_q, cnt_d; // divisor counter
    logic tick_d;
    logic pre_tick;
    // ==========================================================
    // next state
    always_comb begin
        pre_tick = !prescale_on || (pre_q == 2'(`UIS_PRESCALE - 1));
        pre_d = pre_q;
        cnt_d = cnt_q;
        tick_d = 1'b0;
        // zero divisor yields no ticks at all
        if (run && divisor != '0) begin
            pre_d = pre_tick ? 2'h0 : pre_q + 2'h1;
            if (pre_tick) begin
                if (cnt_q >= divisor - DIV_W'(1)) begin
                    cnt_d = '0;
                    tick_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + DIV_W'(1);
                end
            end
        end
    end
    // registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_q <= 2'h0;
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end
endmodule // uis_baud_gen
`default_nettype wire

// ==== bench/uis_core_monitor.sv ====
/*
  checker of the uart support block
  assumes: bound to uis_core ports
*/
`timescale 1ns/1ps
`default_nettype none
module uis_core_monitor #(
    parameter int DIV_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // datapath status
    input wire logic rx_data_available,
    input wire logic rx_fifo_error,
    input wire logic tx_holding_empty,
    input wire logic tx_fifo_full,
    input wire logic tx_shift_empty,
    input wire logic tx_serial,
    // watched outputs
    input wire logic tx_line,
    input wire logic irq,
    input wire logic tx_dma_request,
    input wire logic rx_dma_request,
    input wire logic baud_tick,
    input wire logic uart_clk_run
);
    // ==========================================================
    // register mirrors
    logic [7:0] ier_q;
    logic [7:0] fcr_q;
    logic lcr6_q;
    logic efr4_q;
    logic m1;
    logic ier_off;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ier_q <= 8'h00;
            fcr_q <= 8'h00;
            lcr6_q <= 1'b0;
            efr4_q <= 1'b0;
        end else if (wr) begin
            if (addr == 4'h1) ier_q <= wdata;
            if (addr == 4'h2) fcr_q <= wdata;
            if (addr == 4'h3) lcr6_q <= wdata[6];
            if (addr == 4'hA) efr4_q <= wdata[4];
        end
    end
    // block mode needs fifos on as well
    assign m1 = fcr_q[3] & fcr_q[0];
    // bit 4 is sleep, not an irq enable
    assign ier_off = (ier_q & 8'hEF) == 8'h00;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // assertions
    rx_dma_single_a: assert property (!m1 |-> rx_dma_request == rx_data_available)
        else $error("rx single request wrong");
    tx_dma_single_a: assert property (!m1 |-> tx_dma_request == (tx_holding_empty && tx_shift_empty))
        else $error("tx single request wrong");
    tx_dma_full_a: assert property (m1 && tx_fifo_full |-> !tx_dma_request)
        else $error("tx request when full");
    rx_dma_drop_a: assert property (m1 && (rx_fifo_error || !rx_data_available) |-> !rx_dma_request)
        else $error("rx request not dropped");
    break_low_a: assert property (lcr6_q |-> !tx_line)
        else $error("break not low");
    line_pass_a: assert property (!lcr6_q |-> tx_line == tx_serial)
        else $error("tx line wrong");
    irq_off_a: assert property ((ier_off ##1 ier_off) |-> !irq)
        else $error("irq while disabled");
    sleep_still_a: assert property (!uart_clk_run && $past(!uart_clk_run) |-> !baud_tick)
        else $error("tick while asleep");
    sleep_entry_a: assert property ($fell(uart_clk_run) |->
        $past(ier_q[4] && efr4_q && tx_shift_empty && !rx_data_available))
        else $error("bad sleep entry");
    ident_none_a: assert property (rd && addr == 4'h2 && !irq |=> rdata[5:0] == 6'h01)
        else $error("idle ident wrong");
    ident_pend_a: assert property (rd && addr == 4'h2 && irq |=> !rdata[0])
        else $error("pending ident wrong");
    line_irq_a: assert property (ier_q[2] && rx_fifo_error |-> ##[0:2] irq)
        else $error("no line irq");
    // ==========================================================
    // covers
    sleep_c: cover property ($fell(uart_clk_run));
    block_rx_c: cover property (m1 && rx_dma_request);
    irq_c: cover property ($rose(irq));
endmodule // uis_core_monitor
bind uis_core uis_core_monitor #(.DIV_W(DIV_W)) u_mon (.*);
`default_nettype wire

// ==== bench/uis_host_model.sv ====
/*
  host model: register port master, one-cycle strobes
  assumes: caller enters just after a rising edge
*/
`timescale 1ns/1ps
`default_nettype none
module uis_host_model (
    // clock and read data
    input wire logic clk,
    input wire logic [7:0] rdata,
    // strobes and address
    output logic [3:0] addr = 4'h0,
    output logic [7:0] wdata = 8'h00,
    output logic wr = 1'b0,
    output logic rd = 1'b0
);
    // spare edge after each strobe; sleep off before divisor writes
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // read data is taken in the one cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
        @(posedge clk);
    endtask
endmodule // uis_host_model
`default_nettype wire

// ==== bench/uart_irq_dma_sleep_baud_tb.sv ====
/*
  self-checking bench of the uart support block
  assumes: host model on the port, bench drives status
*/
`timescale 1ns/1ps
`default_nettype none
module uart_irq_dma_sleep_baud_tb;
    import uis_pkg::*;
    // ==========================================================
    // signals
    logic clk, rst, wr, rd, tx_line, irq, tx_dma_request, rx_dma_request, baud_tick;
    logic [3:0] addr, modem_pins;
    logic [7:0] wdata, rdata, d;
    logic rx_data_available, rx_above_trigger, rx_fifo_error, rx_overrun, rx_timeout;
    logic [2:0] rx_head_flags;
    logic tx_holding_empty, tx_above_trigger, tx_free_trigger, tx_fifo_full, tx_shift_empty;
    logic xoff_seen, xon_seen, special_seen, flow_pin_rise, rx_line, tx_serial, uart_clk_run;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    uis_host_model u_host (.*);
    uis_core #(.DIV_W(16)) u_dut (.*);
    // ==========================================================
    // helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic rr(input logic [3:0] a, input logic [7:0] e);
        u_host.reg_rd(a, d);
        chk(d, e);
    endtask
    // one-cycle event pulse: 0 xoff, 1 xon, 2 special, 3 flow pin
    task automatic pulse(input int k);
        {flow_pin_rise, special_seen, xon_seen, xoff_seen} <= 4'h1 << k;
        step(1);
        {flow_pin_rise, special_seen, xon_seen, xoff_seen} <= 4'h0;
        step(1);
    endtask
    // cycles between two baud ticks, sampled on falling edges
    task automatic meas(input logic [7:0] e);
        logic [7:0] n;
        n = 8'h00;
        do @(negedge clk); while (baud_tick !== 1'b1 && ++n < 8'hF0);
        n = 8'h00;
        do begin @(negedge clk); n++; end while (baud_tick !== 1'b1 && n < 8'h40);
        chk(n, e);
    endtask
    task automatic tally_and_finish;
        if (failures == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    // mid-run reset
    task automatic t_reset;
        u_host.reg_wr(4'h8, 8'h05);
        rst <= 1'b1;
        step(3);
        rst <= 1'b0;
        step(1);
        rr(4'h1, 8'h00);
        rr(4'h2, 8'h01);
        rr(4'h3, 8'h1D);
        rr(4'h4, 8'h00);
        rr(4'hA, 8'h00);
        rr(4'h7, 8'h00);
        rr(4'h8, 8'h05);
    endtask
    // each interrupt type and its clear
    task automatic t_prio;
        u_host.reg_wr(4'h1, 8'h2F);
        rx_fifo_error <= 1'b1;
        rx_data_available <= 1'b1;
        tx_holding_empty <= 1'b1;
        step(2);
        chk({7'h00, irq}, 8'h01);
        rr(4'h2, 8'h06);
        rx_fifo_error <= 1'b0;
        step(2);
        rr(4'h2, 8'h04);
        rx_data_available <= 1'b0;
        u_host.reg_rd(4'h0, d);
        rr(4'h2, 8'h02);
        rr(4'h2, 8'h01);
        tx_holding_empty <= 1'b0;
        step(1);
        tx_holding_empty <= 1'b1;
        step(2);
        u_host.reg_wr(4'h0, 8'h55);
        rr(4'h2, 8'h01);
        rx_overrun <= 1'b1;
        step(1);
        rx_overrun <= 1'b0;
        step(1);
        rr(4'h2, 8'h06);
        u_host.reg_rd(4'h5, d);
        rr(4'h2, 8'h01);
        rx_timeout <= 1'b1;
        step(2);
        rr(4'h2, 8'h0C);
        rx_timeout <= 1'b0;
        u_host.reg_rd(4'h0, d);
        rr(4'h2, 8'h01);
        modem_pins <= 4'h1;
        step(2);
        rr(4'h2, 8'h00);
        u_host.reg_rd(4'h6, d);
        rr(4'h2, 8'h01);
        pulse(0);
        rr(4'h2, 8'h10);
        pulse(1);
        rr(4'h2, 8'h01);
        pulse(2);
        rr(4'h2, 8'h10);
        u_host.reg_rd(4'h5, d);
        rr(4'h2, 8'h01);
        pulse(3);
        rr(4'h2, 8'h20);
        rr(4'h2, 8'h01);
        chk({7'h00, irq}, 8'h00);
    endtask
    // polled mode: no irq, status shows fifo error and head flags
    task automatic t_polled;
        u_host.reg_wr(4'h1, 8'h00);
        rx_fifo_error <= 1'b1;
        rx_head_flags <= 3'b101;
        rx_data_available <= 1'b1;
        step(2);
        chk({7'h00, irq}, 8'h00);
        u_host.reg_rd(4'h5, d);
        chk(d & 8'h9C, 8'h94);
        rx_fifo_error <= 1'b0;
        rx_data_available <= 1'b0;
        step(1);
        u_host.reg_rd(4'h5, d);
        chk(d & 8'h9C, 8'h00);
        rx_head_flags <= 3'b000;
    endtask
    // single mode twice (fifo off, mode 0) then block mode
    task automatic t_dma;
        logic [7:0] f [3] = '{8'h00, 8'h08, 8'h09};
        logic m1;
        for (int i = 0; i < 3; i++) begin
            u_host.reg_wr(4'h2, f[i]);
            m1 = (i == 2);
            rx_data_available <= 1'b1;
            tx_holding_empty <= 1'b1;
            step(1);
            #1;
            chk({6'h00, tx_dma_request, rx_dma_request}, m1 ? 8'h00 : 8'h03);
            rx_above_trigger <= 1'b1;
            tx_free_trigger <= 1'b1;
            #1;
            chk({6'h00, tx_dma_request, rx_dma_request}, 8'h03);
            tx_fifo_full <= 1'b1;
            rx_fifo_error <= 1'b1;
            #1;
            chk({6'h00, tx_dma_request, rx_dma_request}, m1 ? 8'h00 : 8'h03);
            {tx_fifo_full, rx_fifo_error, rx_data_available, tx_holding_empty} <= 4'h0;
            #1;
            chk({6'h00, tx_dma_request, rx_dma_request}, m1 ? 8'h02 : 8'h00);
            {rx_above_trigger, tx_free_trigger} <= 2'b00;
            step(1);
        end
        u_host.reg_wr(4'h2, 8'h00);
    endtask
    task automatic t_break;
        u_host.reg_wr(4'h3, 8'h5D);
        chk({7'h00, tx_line}, 8'h00);
        u_host.reg_wr(4'h3, 8'h1D);
        chk({7'h00, tx_line}, 8'h01);
    endtask
    task automatic t_baud;
        u_host.reg_wr(4'h1, 8'h00);
        u_host.reg_wr(4'h8, 8'h04);
        u_host.reg_wr(4'h9, 8'h00);
        meas(8'h04);
        u_host.reg_wr(4'h4, 8'h80);
        meas(8'h10);
        u_host.reg_wr(4'h8, 8'h00);
        step(4);
        d = 8'h00;
        repeat (80) begin @(negedge clk); if (baud_tick === 1'b1) d++; end
        chk(d, 8'h00);
    endtask
    // idle takes 640 ticks, one a cycle
    task automatic t_sleep;
        u_host.reg_wr(4'h4, 8'h00);
        u_host.reg_wr(4'h8, 8'h01);
        tx_holding_empty <= 1'b1;
        u_host.reg_wr(4'hA, 8'h10);
        u_host.reg_wr(4'h1, 8'h10);
        for (int i = 0; i < 1500 && uart_clk_run !== 1'b0; i++) @(negedge clk);
        chk({7'h00, uart_clk_run}, 8'h00);
        d = 8'h00;
        repeat (40) begin @(negedge clk); if (baud_tick === 1'b1) d++; end
        chk(d, 8'h00);
        rr(4'hC, 8'h03);
        rx_line <= 1'b0;
        for (int i = 0; i < 40 && uart_clk_run !== 1'b1; i++) @(negedge clk);
        chk({7'h00, uart_clk_run}, 8'h01);
    endtask
    // ==========================================================
    // clock, hang guard and main sequence
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish;
        end
    end
    initial begin
        rst = 1'b1;
        {rx_data_available, rx_above_trigger, rx_fifo_error, rx_overrun, rx_timeout} = 5'h00;
        {tx_holding_empty, tx_above_trigger, tx_free_trigger, tx_fifo_full} = 4'h0;
        {tx_shift_empty, xoff_seen, xon_seen, special_seen, flow_pin_rise} = 5'h10;
        {rx_head_flags, modem_pins} = 7'h00;
        {rx_line, tx_serial} = 2'b11;
        step(3);
        rst <= 1'b0;
        step(1);
        t_reset;
        t_prio;
        t_polled;
        t_dma;
        t_break;
        t_baud;
        t_sleep;
        tally_and_finish;
    end
endmodule // uart_irq_dma_sleep_baud_tb
`default_nettype wire
